// *** rx_frame_check.sv ***
// Receive frame classification, length checks and padding removal
module rx_frame_check
   import rx_frame_check_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   // APB register port
   input  wire logic [11:0]       paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [31:0]       pwdata_i,
   input  wire logic [3:0]        pstrb_i,
   output logic [31:0]            prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Frame stream from the receive decoder, FCS included
   input  wire logic [DATA_W-1:0] rx_data_i,
   input  wire logic [KEEP_W-1:0] rx_keep_i,
   input  wire logic              rx_valid_i,
   input  wire logic              rx_last_i,
   input  wire logic              rx_fcs_err_i,
   input  wire logic              rx_code_err_i,
   // Client stream, no back-pressure
   output logic [DATA_W-1:0]      m_axis_rx_tdata_o,
   output logic [KEEP_W-1:0]      m_axis_rx_tkeep_o,
   output logic                   m_axis_rx_tvalid_o,
   output logic                   m_axis_rx_tlast_o,
   output logic                   m_axis_rx_tuser_o,
   // Level interrupt
   output logic                   irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [15:0] byte_count(input logic [KEEP_W-1:0] k);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 0; i < KEEP_W; i++)
         c = c + {15'h0000, k[i]};
      return c;
   endfunction

   function automatic logic [KEEP_W-1:0] lead_mask(input logic [15:0] n);
      logic [KEEP_W-1:0] m;
      m = '0;
      for (int i = 0; i < KEEP_W; i++)
         m[i] = (n > 16'(i));
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [CFG_W-1:0]  cfg_r;
   logic [15:0]       mtu_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_mask_r;
   logic [16:0]       last_r;           // {bad, total length}
   rx_state_t         state_r;
   logic [15:0]       cnt_r;            // Bytes taken so far in this frame
   logic [3:0]        idx_r;            // Word index, saturating
   logic [3:0]        tag_cnt_r;
   logic              lt_known_r;
   logic [15:0]       lt_r;
   logic [DATA_W-1:0] hold_data_r;
   logic [15:0]       hold_off_r;
   logic [DATA_W-1:0] park_data_r;
   logic [KEEP_W-1:0] park_keep_r;
   logic              parked_r;
   logic [DATA_W-1:0] tail_data_r;
   logic [KEEP_W-1:0] tail_keep_r;
   logic              tail_good_r;

   logic        apb_go;
   logic        apb_wr;
   logic        apb_hit;
   logic [31:0] wmask;
   logic        beat;
   logic        frame_end;
   logic [15:0] n_bytes;
   logic [15:0] total;
   logic [15:0] type_field;
   logic [3:0]  max_tags;
   logic        vlan_hit;
   logic        is_vlan;
   logic [15:0] header_len;
   logic        lt_used;
   logic        chk_act;
   logic        strip_on;
   logic [15:0] data_end;
   logic [15:0] rem;
   logic        at_end;
   logic [15:0] limit;
   logic [15:0] data_len;
   logic        oversize;
   logic        runt;
   logic        len_err;
   logic        small_err;
   logic        frame_bad;
   logic [IRQ_W-1:0] irq_ev;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   // One wait state so that read data and pready both leave flip-flops
   assign apb_go  = psel_i & penable_i & pready_o;
   assign apb_wr  = apb_go & pwrite_i;
   assign apb_hit = (paddr_i == OFS_CONFIG) | (paddr_i == OFS_MTU) | (paddr_i == OFS_IRQ_STAT)
                  | (paddr_i == OFS_IRQ_MASK) | (paddr_i == OFS_LAST);
   assign wmask   = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

   // Answer, read data and error for the access phase
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~apb_hit;
         prdata_o  <= 32'h0000_0000;
         if (psel_i & penable_i & ~pready_o & ~pwrite_i)
         begin
            unique case (paddr_i)
               OFS_CONFIG:   prdata_o <= {25'h0, cfg_r};
               OFS_MTU:      prdata_o <= {16'h0000, mtu_r};
               OFS_IRQ_STAT: prdata_o <= {28'h0, irq_stat_r};
               OFS_IRQ_MASK: prdata_o <= {28'h0, irq_mask_r};
               OFS_LAST:     prdata_o <= {15'h0, last_r};
               default:      prdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Configuration and MTU; MTU below the floor is software's fault
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         cfg_r      <= CFG_RESET;
         mtu_r      <= MTU_RESET;
         irq_mask_r <= {IRQ_W{1'b0}};                          // All sources masked until software opens them
      end
      else if (apb_wr)
      begin
         if (paddr_i == OFS_CONFIG)
            cfg_r <= (cfg_r & ~wmask[CFG_W-1:0]) | (pwdata_i[CFG_W-1:0] & wmask[CFG_W-1:0]);
         if (paddr_i == OFS_MTU)
            mtu_r <= (mtu_r & ~wmask[15:0]) | (pwdata_i[15:0] & wmask[15:0]);
         if (paddr_i == OFS_IRQ_MASK)
            irq_mask_r <= (irq_mask_r & ~wmask[IRQ_W-1:0]) | (pwdata_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts

   // Sticky per event; a new event beats a write-one clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < IRQ_W; gi++)
      begin : g_irq
         always_ff @(posedge clk_i)
         begin
            if (srst_i)
               irq_stat_r[gi] <= 1'b0;
            else if (irq_ev[gi])
               irq_stat_r[gi] <= 1'b1;
            else if (apb_wr && paddr_i == OFS_IRQ_STAT && pwdata_i[gi] && pstrb_i[0])
               irq_stat_r[gi] <= 1'b0;
         end
      end
   endgenerate

   // Level interrupt, one cycle behind the status bits
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(irq_stat_r & irq_mask_r);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Header parse and frame checks

   assign beat       = rx_valid_i;
   assign frame_end  = rx_valid_i & rx_last_i;
   assign n_bytes    = byte_count(rx_keep_i);
   assign total      = cnt_r + n_bytes;
   assign type_field = {rx_data_i[7:0], rx_data_i[15:8]};   // Network order, first byte high
   assign max_tags   = cfg_r[CFG_STACKED] ? MAX_TAGS_STK : MAX_TAGS_ONE;
   // Either TPID accepted in any tag slot when stacked tags are on
   assign vlan_hit   = cfg_r[CFG_VLAN] & (tag_cnt_r < max_tags)
                     & ((type_field == TPID_CTAG)
                        | (cfg_r[CFG_STACKED] & (type_field == TPID_STAG)));
   assign is_vlan    = (tag_cnt_r != 4'h0);
   assign header_len = BASE_HDR + {10'h000, tag_cnt_r, 2'b00};
   // Tagged frames only get a length interpretation when the CFG_VLAN_LEN bit is on
   assign lt_used    = lt_known_r & (~is_vlan | cfg_r[CFG_VLAN_LEN]);
   // Control frame types sit above the floor and fall out here too
   assign chk_act    = cfg_r[CFG_LEN_CHK] & lt_used & (lt_r < TYPE_FLOOR);
   assign strip_on   = chk_act & ~cfg_r[CFG_FCS_PASS];
   assign data_end   = header_len + lt_r;
   assign rem        = (data_end > hold_off_r) ? data_end - hold_off_r : 16'h0000;
   assign at_end     = strip_on & (rem <= 16'(WORD_BYTES));
   assign limit      = cfg_r[CFG_MTU_EN] ? mtu_r
                     : (is_vlan ? MAX_TAGGED : MAX_UNTAGGED);
   assign oversize   = ~cfg_r[CFG_JUMBO] & (total > limit);
   assign runt       = (total < MIN_FRAME);
   assign data_len   = total - 16'(FCS_BYTES) - header_len;
   // Short real data against the field; with the check off this is not looked at
   assign len_err    = chk_act & (lt_r >= MIN_DATA) & (data_len < lt_r);
   // Short length needs an exact minimum frame even with the check off
   assign small_err  = lt_used & (lt_r < MIN_DATA) & (total != MIN_FRAME);
   assign frame_bad  = rx_fcs_err_i | rx_code_err_i | runt | oversize | len_err | small_err;
   assign irq_ev     = frame_end ? {oversize, len_err | small_err, frame_bad, ~frame_bad}
                                 : {IRQ_W{1'b0}};

   // Byte counter, word index and tag walk
   always_ff @(posedge clk_i)
   begin
      if (srst_i | frame_end)
      begin
         cnt_r      <= 16'h0000;
         idx_r      <= 4'h0;
         tag_cnt_r  <= 4'h0;
         lt_known_r <= 1'b0;
         lt_r       <= 16'h0000;
      end
      else if (beat)
      begin
         cnt_r <= (total < cnt_r) ? 16'hffff : total;   // Saturate on huge jumbos
         if (idx_r != 4'hf)
            idx_r <= idx_r + 4'h1;
         if (!lt_known_r && idx_r == TYPE_WORD + tag_cnt_r)
         begin
            if (vlan_hit)
               tag_cnt_r <= tag_cnt_r + 4'h1;
            else
            begin
               lt_known_r <= 1'b1;
               lt_r       <= type_field;
            end
         end
      end
   end

   // Last frame status for software
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         last_r <= 17'h0_0000;
      else if (frame_end)
         last_r <= {frame_bad, total};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output sequencing

   // One word is held back so FCS bytes can be trimmed when the end shows up
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_r            <= ST_IDLE;
         hold_data_r        <= '0;
         hold_off_r         <= 16'h0000;
         park_data_r        <= '0;
         park_keep_r        <= '0;
         parked_r           <= 1'b0;
         tail_data_r        <= '0;
         tail_keep_r        <= '0;
         tail_good_r        <= 1'b0;
         m_axis_rx_tdata_o  <= '0;
         m_axis_rx_tkeep_o  <= '0;
         m_axis_rx_tvalid_o <= 1'b0;
         m_axis_rx_tlast_o  <= 1'b0;
         m_axis_rx_tuser_o  <= 1'b0;
      end
      else
      begin
         m_axis_rx_tvalid_o <= 1'b0;
         m_axis_rx_tlast_o  <= 1'b0;
         m_axis_rx_tuser_o  <= 1'b0;
         unique case (state_r)
            ST_IDLE:
            begin
               parked_r <= 1'b0;
               if (beat && !rx_last_i)
               begin
                  hold_data_r <= rx_data_i;
                  hold_off_r  <= cnt_r;
                  state_r     <= ST_FRAME;
               end
               else if (frame_end)
               begin
                  // A one-word frame is a runt: deliver it flagged bad
                  m_axis_rx_tdata_o  <= rx_data_i;
                  m_axis_rx_tkeep_o  <= rx_keep_i;
                  m_axis_rx_tvalid_o <= 1'b1;
                  m_axis_rx_tlast_o  <= 1'b1;
                  m_axis_rx_tuser_o  <= 1'b0;
               end
            end
            ST_FRAME:
            begin
               if (beat && !rx_last_i)
               begin
                  if (!at_end)
                  begin
                     m_axis_rx_tdata_o  <= hold_data_r;
                     m_axis_rx_tkeep_o  <= {KEEP_W{1'b1}};
                     m_axis_rx_tvalid_o <= 1'b1;
                  end
                  else if (!parked_r && rem != 16'h0000)
                  begin
                     // Last data word kept back so it can close the frame
                     park_data_r <= hold_data_r;
                     park_keep_r <= lead_mask(rem);
                     parked_r    <= 1'b1;
                  end
                  hold_data_r <= rx_data_i;
                  hold_off_r  <= cnt_r;
               end
               else if (frame_end && cfg_r[CFG_FCS_PASS])
               begin
                  // FCS goes to the client; last beat follows a cycle later
                  m_axis_rx_tdata_o  <= hold_data_r;
                  m_axis_rx_tkeep_o  <= {KEEP_W{1'b1}};
                  m_axis_rx_tvalid_o <= 1'b1;
                  tail_data_r        <= rx_data_i;
                  tail_keep_r        <= rx_keep_i;
                  tail_good_r        <= ~frame_bad;
                  state_r            <= ST_TAIL;
               end
               else if (frame_end)
               begin
                  // Final beat length equals last-beat byte count, or rem when padding is stripped: FCS trimmed off
                  m_axis_rx_tdata_o  <= parked_r ? park_data_r : hold_data_r;
                  m_axis_rx_tkeep_o  <= parked_r ? park_keep_r
                                      : (rx_keep_i & (at_end ? lead_mask(rem)
                                                              : {KEEP_W{1'b1}}));
                  m_axis_rx_tvalid_o <= 1'b1;
                  m_axis_rx_tlast_o  <= 1'b1;
                  m_axis_rx_tuser_o  <= ~frame_bad;
                  parked_r           <= 1'b0;
                  state_r            <= ST_IDLE;
               end
            end
            ST_TAIL:
            begin
               m_axis_rx_tdata_o  <= tail_data_r;
               m_axis_rx_tkeep_o  <= tail_keep_r;
               m_axis_rx_tvalid_o <= 1'b1;
               m_axis_rx_tlast_o  <= 1'b1;
               m_axis_rx_tuser_o  <= tail_good_r;
               parked_r           <= 1'b0;
               state_r            <= ST_IDLE;
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

endmodule

// *** rx_frame_check_pkg.sv ***
// Constants, register map and state codes for the receive frame checker
package rx_frame_check_pkg;

   // Stream geometry
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned KEEP_W        = 4;
   localparam int unsigned WORD_BYTES    = 4;
   localparam int unsigned FCS_BYTES     = 4;

   // Frame size limits in bytes, FCS included, then data and length/type field bounds
   localparam logic [15:0] MIN_FRAME     = 16'h0040;  // 64
   localparam logic [15:0] MAX_UNTAGGED  = 16'h05ee;  // 1518
   localparam logic [15:0] MAX_TAGGED    = 16'h05f2;  // 1522
   localparam logic [15:0] MIN_MTU       = 16'h05ee;  // 1518
   localparam logic [15:0] MIN_DATA      = 16'h002e;  // 46
   localparam logic [15:0] TYPE_FLOOR    = 16'h0600;  // 1536

   // Header layout
   localparam logic [15:0] BASE_HDR      = 16'h000e;  // 14: DA, SA, length/type
   localparam logic [3:0]  TYPE_WORD     = 4'h3;      // Word holding bytes 12..15
   localparam logic [15:0] TPID_CTAG     = 16'h8100;
   localparam logic [15:0] TPID_STAG     = 16'h88a8;
   localparam logic [3:0]  MAX_TAGS_ONE  = 4'h1;
   localparam logic [3:0]  MAX_TAGS_STK  = 4'h8;

   // Register byte offsets
   localparam logic [11:0] OFS_CONFIG    = 12'h000;
   localparam logic [11:0] OFS_MTU       = 12'h004;
   localparam logic [11:0] OFS_IRQ_STAT  = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK  = 12'h00c;
   localparam logic [11:0] OFS_LAST      = 12'h010;

   // Configuration bit positions
   localparam int unsigned CFG_VLAN      = 0;
   localparam int unsigned CFG_STACKED   = 1;
   localparam int unsigned CFG_VLAN_LEN  = 2;
   localparam int unsigned CFG_LEN_CHK   = 3;
   localparam int unsigned CFG_JUMBO     = 4;
   localparam int unsigned CFG_MTU_EN    = 5;
   localparam int unsigned CFG_FCS_PASS  = 6;
   localparam int unsigned CFG_W         = 7;
   localparam logic [6:0]  CFG_RESET     = 7'h08;     // Length check on
   localparam logic [15:0] MTU_RESET     = 16'h05ee;

   // Interrupt event bits
   localparam int unsigned IRQ_GOOD      = 0;
   localparam int unsigned IRQ_BAD       = 1;
   localparam int unsigned IRQ_LEN       = 2;
   localparam int unsigned IRQ_BIG       = 3;
   localparam int unsigned IRQ_W         = 4;

   // Frame sequencing states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FRAME = 3'b010,
      ST_TAIL  = 3'b100
   } rx_state_t;

endpackage

// *** rx_frame_check_asserts.sv ***
// Port-level assertions for the receive frame checker
module rx_frame_check_asserts
   import rx_frame_check_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire logic [11:0]       paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic [31:0]       prdata_o,
   input  wire logic              pready_o,
   input  wire logic              pslverr_o,
   input  wire logic              rx_valid_i,
   input  wire logic              rx_last_i,
   input  wire logic              rx_fcs_err_i,
   input  wire logic              rx_code_err_i,
   input  wire logic [KEEP_W-1:0] m_axis_rx_tkeep_o,
   input  wire logic              m_axis_rx_tvalid_o,
   input  wire logic              m_axis_rx_tlast_o,
   input  wire logic              m_axis_rx_tuser_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   // Bad status within two cycles, the later one covering the passed FCS tail
   sequence bad_end;
      ##[1:2] (m_axis_rx_tlast_o && !m_axis_rx_tuser_o);
   endsequence

   ////////////////////////////////////////////////////////////
   // Register port: exactly one wait state, answer stands one cycle
   a_apb_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("pready late");
   a_apb_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("prdata not zero while idle");
   a_apb_unmapped: assert property (psel_i && penable_i && !pready_o && paddr_i > OFS_LAST |=> pslverr_o)
      else $error("no slave error on unmapped address");
   a_slverr_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");

   ////////////////////////////////////////////////////////////
   // Client stream: status only on the final beat
   a_user_on_last: assert property (m_axis_rx_tuser_o |-> m_axis_rx_tlast_o && m_axis_rx_tvalid_o)
      else $error("tuser outside final beat");
   a_last_follows: assert property (rx_valid_i && rx_last_i |-> ##[1:2] m_axis_rx_tlast_o)
      else $error("frame end not reported");
   a_fcs_err_bad: assert property (rx_valid_i && rx_last_i && rx_fcs_err_i |-> bad_end)
      else $error("FCS failure reported good");
   a_code_err_bad: assert property (rx_valid_i && rx_last_i && rx_code_err_i |-> bad_end)
      else $error("code error reported good");
   a_keep_contig: assert property (m_axis_rx_tvalid_o |-> m_axis_rx_tkeep_o inside {4'h1, 4'h3, 4'h7, 4'hf})
      else $error("tkeep not a low-lane mask");
   a_keep_full_mid: assert property (m_axis_rx_tvalid_o && !m_axis_rx_tlast_o |-> m_axis_rx_tkeep_o == 4'hf)
      else $error("partial tkeep before frame end");
   a_beat_source: assert property (m_axis_rx_tvalid_o && !m_axis_rx_tlast_o |-> $past(rx_valid_i))
      else $error("data beat without input beat");

   // Main scenarios
   c_good_end: cover property (m_axis_rx_tlast_o && m_axis_rx_tuser_o);
   c_bad_end: cover property (m_axis_rx_tlast_o && !m_axis_rx_tuser_o);
   c_slave_err: cover property (pready_o && pslverr_o);
endmodule

bind rx_frame_check rx_frame_check_asserts chk_u (.clk_i, .srst_i, .paddr_i, .psel_i, .penable_i, .prdata_o,
   .pready_o, .pslverr_o, .rx_valid_i, .rx_last_i, .rx_fcs_err_i, .rx_code_err_i, .m_axis_rx_tkeep_o,
   .m_axis_rx_tvalid_o, .m_axis_rx_tlast_o, .m_axis_rx_tuser_o);

// *** rx_client_model.sv ***
// Client model that absorbs the receive stream and reports each frame
module rx_client_model
   import rx_frame_check_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire logic [DATA_W-1:0] tdata_i,
   input  wire logic [KEEP_W-1:0] tkeep_i,
   input  wire logic              tvalid_i,
   input  wire logic              tlast_i,
   input  wire logic              tuser_i,
   output logic                   done_o,
   output logic                   good_o,
   output logic [15:0]            bytes_o,
   output logic [31:0]            tag_word_o
);
   logic [15:0] cnt_r;

   ////////////////////////////////////////////////////////////
   // Every beat is taken: the stream has no back-pressure to stall with
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         cnt_r <= 16'h0000;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= tvalid_i && tlast_i;
         if (tvalid_i)
            cnt_r <= tlast_i ? 16'h0000 : cnt_r + 16'($countones(tkeep_i));
         if (tvalid_i && cnt_r == 16'h000c)
            tag_word_o <= tdata_i; // Bytes 12..15: type or first tag
         if (tvalid_i && tlast_i)
         begin
            good_o <= tuser_i; // Low status marks a bad frame; its bytes are still reported
            bytes_o <= cnt_r + 16'($countones(tkeep_i));
         end
      end
   end
endmodule

// *** rx_frame_check_tb.sv ***
// Self-checking bench for the receive frame checker
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module rx_frame_check_tb
   import rx_frame_check_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk, srst, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rdv, tagw;
   logic [DATA_W-1:0] rx_data, tdata;
   logic [KEEP_W-1:0] rx_keep, tkeep;
   logic              rx_valid, rx_last, fcs_err, code_err, tvalid, tlast, tuser, done, good, err;
   logic [15:0]       nbytes, mtu;
   logic [6:0]        cfg;
   logic [7:0]        b [0:2303];
   int                num_errors, samples_checked, seed, i, t, l;

   rx_frame_check dut_u (.clk_i(clk), .srst_i(srst), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .rx_data_i(rx_data), .rx_keep_i(rx_keep), .rx_valid_i(rx_valid), .rx_last_i(rx_last),
      .rx_fcs_err_i(fcs_err), .rx_code_err_i(code_err), .m_axis_rx_tdata_o(tdata), .m_axis_rx_tkeep_o(tkeep),
      .m_axis_rx_tvalid_o(tvalid), .m_axis_rx_tlast_o(tlast), .m_axis_rx_tuser_o(tuser), .irq_o(irq));
   rx_client_model client_u (.clk_i(clk), .srst_i(srst), .tdata_i(tdata), .tkeep_i(tkeep), .tvalid_i(tvalid),
      .tlast_i(tlast), .tuser_i(tuser), .done_o(done), .good_o(good), .bytes_o(nbytes), .tag_word_o(tagw));

   always #50 clk = ~clk;

   ////////////////////////////////////////////////////////////
   // Expected {oversize, length error, bad, delivered bytes} for the current configuration
   function automatic logic [18:0] expect_frame(input int tot, input logic [15:0] lt, input int nt,
                                                input logic [1:0] fe);
      int  hdr, dl, lim, out;
      logic bad, lenint, big, lerr;
      hdr = BASE_HDR + 4 * nt;
      dl = tot - hdr - FCS_BYTES;
      lenint = lt < TYPE_FLOOR && (nt == 0 || cfg[CFG_VLAN_LEN]);
      bad = (fe != 2'b00) || tot < MIN_FRAME;
      lim = cfg[CFG_MTU_EN] ? int'(mtu) : (nt > 0 ? int'(MAX_TAGGED) : int'(MAX_UNTAGGED));
      big = !cfg[CFG_JUMBO] && tot > lim;
      lerr = lenint && ((lt < MIN_DATA && tot != MIN_FRAME) || (cfg[CFG_LEN_CHK] && lt >= MIN_DATA && dl < lt));
      out = cfg[CFG_FCS_PASS] ? tot : tot - FCS_BYTES;
      if (lenint && cfg[CFG_LEN_CHK] && !cfg[CFG_FCS_PASS] && dl > lt)
         out = hdr + lt;
      return {big, lerr, bad || big || lerr, 16'(out)};
   endfunction

   task automatic test_done();
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One APB transfer; a free cycle first keeps psel from toggling twice at one edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      rdv = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 40)
      begin
         num_errors++;
         test_done();
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdv, e)
   endtask

   // Send one frame with random gaps, then check stream, status and interrupt
   task automatic run(input logic [6:0] c, input int tot, input logic [15:0] lt, input int nt,
                      input logic [1:0] fe);
      logic [18:0] ex;
      int          n, rec;
      if (c != cfg)
         apb(1'b1, OFS_CONFIG, {25'h0, c});
      cfg = c;
      rec = c[CFG_VLAN] ? nt : 0;
      ex = expect_frame(tot, (nt > rec) ? TPID_CTAG : lt, rec, fe);
      for (n = 0; n < tot + 3; n++)
         b[n] = 8'($random(seed));
      for (n = 0; n < nt; n++)
         {b[12+4*n], b[13+4*n]} = (c[CFG_STACKED] && !n[0]) ? TPID_STAG : TPID_CTAG;
      {b[12+4*nt], b[13+4*nt]} = lt;
      @(posedge clk);
      for (n = 0; n < (tot + 3) / 4; n++)
      begin
         if (($random(seed) & 7) == 0)
         begin
            rx_valid <= 1'b0;
            @(posedge clk);
         end
         {rx_valid, fcs_err, code_err, rx_data} <= {1'b1, fe, b[4*n+3], b[4*n+2], b[4*n+1], b[4*n]};
         rx_keep <= (tot - 4 * n >= 4) ? 4'hf : 4'((1 << (tot - 4 * n)) - 1);
         rx_last <= (4 * n + 4 >= tot);
         @(posedge clk);
      end
      {rx_valid, rx_last} <= 2'b00;
      n = 0;
      while (done !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 50)
      begin
         num_errors++;
         test_done();
      end
      `CHK(good, ~ex[16])
      `CHK(nbytes, ex[15:0])
      `CHK(tagw, {b[15], b[14], b[13], b[12]})
      rd(OFS_LAST, {15'h0, ex[16], 16'(tot)});
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      `CHK(rdv[3:0], {ex[18:16], ~ex[16]})
      `CHK(irq, ex[16])
      apb(1'b1, OFS_IRQ_STAT, 32'hf);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      num_errors++;
      test_done();
   end

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {clk, srst, psel, penable, pwrite, rx_valid, rx_last, fcs_err, code_err} = 9'h080;
      {paddr, pwdata, rx_data, rx_keep} = '0;
      {seed, cfg, mtu, num_errors, samples_checked} = {32'h606b47a1, CFG_RESET, MTU_RESET, 64'h0};
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd(OFS_CONFIG, {25'h0, CFG_RESET});
      rd(OFS_MTU, {16'h0, MTU_RESET});
      rd(OFS_IRQ_STAT, 32'h0);
      rd(OFS_IRQ_MASK, 32'h0);
      rd(OFS_LAST + 12'h004, 32'h0);
      `CHK(err, 1'b1)
      apb(1'b1, OFS_IRQ_MASK, 32'h2);
      run(7'h08, 80, 16'h0800, 0, 0);
      run(7'h08, 80, 16'd100, 0, 0);
      run(7'h08, 80, 16'd50, 0, 0);
      run(7'h08, 64, 16'd20, 0, 0);
      run(7'h08, 70, 16'd20, 0, 0);
      run(7'h08, 64, 16'd46, 0, 0);
      run(7'h08, 1518, 16'h0800, 0, 0);
      run(7'h08, 1519, 16'h0800, 0, 0);
      run(7'h08, 80, 16'h0800, 0, 1);
      run(7'h08, 80, 16'h0800, 0, 2);
      run(7'h08, 80, 16'd20, 1, 0);
      run(7'h00, 80, 16'd100, 0, 0);
      run(7'h00, 70, 16'd20, 0, 0);
      run(7'h00, 64, 16'd20, 0, 0);
      run(7'h09, 64, 16'd20, 1, 0);
      run(7'h09, 1522, 16'h0800, 1, 0);
      run(7'h09, 1523, 16'h0800, 1, 0);
      run(7'h0d, 80, 16'd50, 1, 0);
      run(7'h0d, 80, 16'd100, 1, 0);
      run(7'h0b, 1522, 16'h0800, 8, 0);
      run(7'h0b, 1523, 16'h0800, 8, 0);
      run(7'h0f, 200, 16'd50, 8, 0);
      run(7'h18, 2000, 16'h0800, 0, 0);
      apb(1'b1, OFS_MTU, 32'd2000);
      mtu = 16'd2000;
      run(7'h28, 2000, 16'h0800, 0, 0);
      run(7'h28, 2001, 16'h0800, 0, 0);
      run(7'h38, 2100, 16'h0800, 0, 0);
      run(7'h48, 64, 16'd20, 0, 0);
      run(7'h48, 64, 16'd20, 0, 1);
      for (i = 0; i < 16; i++)
      begin
         t = 64 + ($random(seed) & 255);
         l = ($random(seed) & 1) ? 16'h0800 : $random(seed) & 16'h007f;
         run(7'($random(seed)) & 7'h48, t, 16'(l), 0, 0);
      end
      test_done();
   end
endmodule
